/* design/bcm_ctrl.sv */
// Contract
// - PWM: high side on at period start
// - Dead time, rectifier, then next period
// - Mode pin high: forced PWM, no DCM
// - Duty limited to 10..100 percent
// - Enter power save after 32 periods
// - PFM pulse: high side, rectifier, repeat
// - Keep switching until 0.8% above
// - Leave power save at 1.6% below
// - Soft-start current limit in steps
// - Rectifier off until ramp passes pre-bias
// - Dropout holds high side on
// - Enable low: all off, flag low
// - Over-temperature keeps reference on
// - Enable rising starts soft start
// - Undervoltage: both switches off
// - Over-temperature: switches off, flag floats
// - Internal oscillator about 1 MHz
// - Lock on first sync rising edge
// - Four silent periods: back internal
// - Locked: power save disabled
// - Sync low: power save allowed
// - Flag valid 250 us after enable
//
// Design decisions made here: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "bcm_defines.svh"

module bcm_ctrl #(
  parameter int OSC_DIV   = `BCM_OSC_DIV,
  parameter int SS_STEP   = `BCM_SS_STEP_CYC,
  parameter int PG_DELAY  = `BCM_PG_DELAY_CYC,
  parameter int SYNC_LOSS = `BCM_SYNC_LOSS_CYC,
  parameter int PFM_ENTRY = `BCM_PFM_ENTRY_PER,
  parameter int MIN_ON    = `BCM_MIN_ON_CYC,
  parameter int DEAD      = `BCM_DEAD_CYC
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output wire logic        s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output wire logic        s_axi_wready,
  output wire logic [1:0]  s_axi_bresp,
  output wire logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output wire logic        s_axi_arready,
  output wire logic [31:0] s_axi_rdata,
  output wire logic [1:0]  s_axi_rresp,
  output wire logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        enable_pin,
  input  wire logic        sync_pin,
  input  wire logic        input_undervoltage_lockout,
  input  wire logic        over_temp,
  input  wire logic        reg_trip,
  input  wire logic        hs_cur_limit,
  input  wire logic        low_avg_cur,
  input  wire logic        out_below_nom,
  input  wire logic        out_above_hi,
  input  wire logic        out_below_low,
  input  wire logic        ind_cur_zero,
  input  wire logic        ramp_above_prebias,
  input  wire logic        vin_near_vout,
  input  wire logic        out_good_cmp,
  input  wire logic        low_supply_cmp,
  input  wire logic        output_in_regulation_flag_i,
  output wire logic        output_in_regulation_flag_o,
  output wire logic        output_in_regulation_flag_oe_n,
  input  wire logic        low_supply_warning_out_i,
  output wire logic        low_supply_warning_out_o,
  output wire logic        low_supply_warning_out_oe_n,
  output wire logic        hs_gate,
  output wire logic        ls_gate,
  output wire logic        ref_on,
  output wire logic        osc_on,
  output wire logic [1:0]  ilim_step
);

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  bcm_sync_if #(.W(`BCM_IN_W)) sif ();

  assign sif.raw = {low_supply_warning_out_i, output_in_regulation_flag_i,
                    low_supply_cmp, out_good_cmp, vin_near_vout,
                    ramp_above_prebias, ind_cur_zero, out_below_low,
                    out_above_hi, out_below_nom, low_avg_cur, hs_cur_limit,
                    reg_trip, over_temp, input_undervoltage_lockout,
                    sync_pin, enable_pin};

  bcm_sync #(.W(`BCM_IN_W)) u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .s       (sif.syn)
  );

  bcm_pkg::bcm_state_t s_r;
  bcm_pkg::bcm_state_t s_nxt;
  logic [`BCM_IN_W-1:0] in_s;
  logic                 en_s;
  logic                 input_undervoltage_lockout_s;
  logic                 ot_s;
  logic                 osc_wrap;
  logic                 sync_rise;
  logic                 en_rise;
  logic                 ps;
  logic                 active;
  logic                 forced;
  logic                 pwm_go;
  logic [31:0]          status_word;

  // ****************************************************************
  // Derived events
  // ****************************************************************
  assign in_s      = sif.sync;
  assign en_s      = in_s[`BCM_IX_EN];
  assign input_undervoltage_lockout_s    = in_s[`BCM_IX_INPUT_UNDERVOLTAGE_LOCKOUT];
  assign ot_s      = in_s[`BCM_IX_OT];
  assign osc_wrap  = (s_r.osc_cnt == 4'(OSC_DIV - 1));
  assign sync_rise = in_s[`BCM_IX_SYNC] && !s_r.sync_prev;
  assign en_rise   = en_s && !s_r.en_prev;
  assign ps        = s_r.sync_lock ? sync_rise : osc_wrap;
  assign active    = en_s && !input_undervoltage_lockout_s && !ot_s;
  // lock or high pin forces PWM
  assign forced    = in_s[`BCM_IX_SYNC] || s_r.sync_lock || s_r.force_pwm;
  // PFM pulse start, later at period rate
  assign pwm_go    = s_r.pfm ? (s_r.burst && (!s_r.pulsed || ps)) : ps;

  // Status word assembly
  always_comb
  begin
    status_word                   = 32'h00000000;
    status_word[`BCM_ST_RUN]      = s_r.run;
    status_word[`BCM_ST_PFM]      = s_r.pfm;
    status_word[`BCM_ST_LOCK]     = s_r.sync_lock;
    status_word[`BCM_ST_SSDONE]   = s_r.ss_done;
    status_word[`BCM_ST_ILIM_LO]  = s_r.ilim[0];
    status_word[`BCM_ST_ILIM_HI]  = s_r.ilim[1];
    status_word[`BCM_ST_PGVALID]  = s_r.pg_valid;
    status_word[`BCM_ST_HS]       = s_r.hs;
    status_word[`BCM_ST_LS]       = s_r.ls;
    status_word[`BCM_ST_PGPIN]    = in_s[`BCM_IX_PGPIN];
    status_word[`BCM_ST_LBOPIN]   = in_s[`BCM_IX_LBOPIN];
    status_word[`BCM_ST_PREBIAS]  = s_r.prebias_ok;
  end

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  always_comb
  begin
    s_nxt           = s_r;
    s_nxt.sync_prev = in_s[`BCM_IX_SYNC];
    s_nxt.en_prev   = en_s;
    s_nxt.run       = active;
    s_nxt.osc_on    = en_s;
    s_nxt.ph_cnt    = s_r.ph_cnt + 4'h1;

    if (sync_rise)
    begin
      s_nxt.sync_lock = 1'b1;
      s_nxt.sync_cnt  = 6'h00;
    end
    else if (s_r.sync_lock)
    begin
      if (s_r.sync_cnt == 6'(SYNC_LOSS - 1))
        s_nxt.sync_lock = 1'b0;
      else
        s_nxt.sync_cnt = s_r.sync_cnt + 6'h01;
    end

    // Internal oscillator divider
    if (osc_wrap || sync_rise || !en_s)
      s_nxt.osc_cnt = 4'h0;
    else
      s_nxt.osc_cnt = s_r.osc_cnt + 4'h1;

    if (en_rise)
    begin
      s_nxt.ss_step    = 2'h0;
      s_nxt.ss_cnt     = 12'h000;
      s_nxt.ss_done    = 1'b0;
      s_nxt.prebias_ok = 1'b0;
    end
    else if (active && !s_r.ss_done)
    begin
      if (s_r.ss_cnt == 12'(SS_STEP - 1))
      begin
        s_nxt.ss_cnt = 12'h000;
        if (s_r.ss_step == 2'h2)
          s_nxt.ss_done = 1'b1;
        else
          s_nxt.ss_step = s_r.ss_step + 2'h1;
      end
      else
        s_nxt.ss_cnt = s_r.ss_cnt + 12'h001;
    end
    s_nxt.ilim = s_nxt.ss_done ? 2'h3 : s_nxt.ss_step;

    if (!en_rise && active && in_s[`BCM_IX_PREBIAS])
      s_nxt.prebias_ok = 1'b1;

    if (!in_s[`BCM_IX_LOWAVG] || forced || !active)
      s_nxt.low_cnt = 6'h00;
    else if (ps && s_r.low_cnt != 6'(PFM_ENTRY))
      s_nxt.low_cnt = s_r.low_cnt + 6'h01;

    if (!active || forced || in_s[`BCM_IX_LOW16])
      s_nxt.pfm = 1'b0;
    else if (s_r.low_cnt == 6'(PFM_ENTRY))
      s_nxt.pfm = 1'b1;

    if (!s_r.pfm || in_s[`BCM_IX_ABOVE])
    begin
      s_nxt.burst  = 1'b0;
      s_nxt.pulsed = 1'b0;
    end
    else if (in_s[`BCM_IX_BELOW])
      s_nxt.burst = 1'b1;

    // Power stage sequencing
    case (s_r.phase)
      bcm_pkg::PH_IDLE:
      begin
        if (pwm_go)
        begin
          s_nxt.phase  = bcm_pkg::PH_DEAD_H;
          s_nxt.ph_cnt = 4'h0;
          s_nxt.pulsed = s_r.pfm;
        end
      end
      bcm_pkg::PH_DEAD_H:
      begin
        if (s_r.ph_cnt >= 4'(DEAD - 1))
        begin
          s_nxt.phase  = bcm_pkg::PH_HS;
          s_nxt.ph_cnt = 4'h0;
        end
      end
      bcm_pkg::PH_HS:
      begin
        if (in_s[`BCM_IX_CLIM])
        begin
          s_nxt.phase  = bcm_pkg::PH_DEAD_L;
          s_nxt.ph_cnt = 4'h0;
        end
        else if (!s_r.pfm && !in_s[`BCM_IX_DROP] && in_s[`BCM_IX_TRIP]
                 && s_r.ph_cnt >= 4'(MIN_ON - 1))
        begin
          s_nxt.phase  = bcm_pkg::PH_DEAD_L;
          s_nxt.ph_cnt = 4'h0;
        end
      end
      bcm_pkg::PH_DEAD_L:
      begin
        if (s_r.ph_cnt >= 4'(DEAD - 1))
        begin
          s_nxt.ph_cnt = 4'h0;
          if (s_nxt.prebias_ok)
            s_nxt.phase = bcm_pkg::PH_LS;
          else
            s_nxt.phase = bcm_pkg::PH_IDLE;
        end
      end
      bcm_pkg::PH_LS:
      begin
        if (ps && !s_r.pfm)
        begin
          s_nxt.phase  = bcm_pkg::PH_DEAD_H;
          s_nxt.ph_cnt = 4'h0;
        end
        else if (in_s[`BCM_IX_ZERO] && (s_r.pfm || !forced))
          s_nxt.phase = bcm_pkg::PH_IDLE;
      end
      default:
        s_nxt.phase = bcm_pkg::PH_IDLE;
    endcase

    if (!active)
    begin
      s_nxt.phase  = bcm_pkg::PH_IDLE;
      s_nxt.ph_cnt = 4'h0;
    end
    s_nxt.hs = (s_nxt.phase == bcm_pkg::PH_HS);
    s_nxt.ls = (s_nxt.phase == bcm_pkg::PH_LS);

    if (!en_s || input_undervoltage_lockout_s)
    begin
      s_nxt.pg_cnt   = 12'h000;
      s_nxt.pg_valid = 1'b0;
    end
    else if (s_r.pg_cnt == 12'(PG_DELAY - 1))
      s_nxt.pg_valid = 1'b1;
    else
      s_nxt.pg_cnt = s_r.pg_cnt + 12'h001;

    s_nxt.pg_oe_n  = en_s && (ot_s || (s_nxt.pg_valid
                     && in_s[`BCM_IX_GOOD]));
    s_nxt.lbo_oe_n = !en_s || !in_s[`BCM_IX_LBTRIP];
    s_nxt.ref_on   = en_s || ot_s;

    // AXI4-Lite write channel
    s_nxt.awready = 1'b0;
    if (s_r.bvalid && s_axi_bready)
      s_nxt.bvalid = 1'b0;
    if (s_r.awready)
    begin
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp  = `BCM_RESP_OKAY;
      if (s_axi_awaddr == `BCM_ADDR_CTRL)
      begin
        if (s_axi_wstrb[0])
          s_nxt.force_pwm = s_axi_wdata[`BCM_CTRL_FPWM];
      end
      else if (s_axi_awaddr != `BCM_ADDR_STATUS)
        s_nxt.bresp = `BCM_RESP_SLVERR;
    end
    else if (s_axi_awvalid && s_axi_wvalid && !s_r.bvalid)
      s_nxt.awready = 1'b1;

    // AXI4-Lite read channel
    s_nxt.arready = 1'b0;
    if (s_r.rvalid && s_axi_rready)
      s_nxt.rvalid = 1'b0;
    if (s_r.arready)
    begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rresp  = `BCM_RESP_OKAY;
      if (s_axi_araddr == `BCM_ADDR_CTRL)
        s_nxt.rdata = {31'h00000000, s_r.force_pwm};
      else if (s_axi_araddr == `BCM_ADDR_STATUS)
        s_nxt.rdata = status_word;
      else
      begin
        s_nxt.rdata = 32'h00000000;
        s_nxt.rresp = `BCM_RESP_SLVERR;
      end
    end
    else if (s_axi_arvalid && !s_r.rvalid)
      s_nxt.arready = 1'b1;
  end

  // State register
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_r          <= '0;
      s_r.lbo_oe_n <= 1'b1;
    end
    else
      s_r <= s_nxt;
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign s_axi_awready                  = s_r.awready;
  assign s_axi_wready                   = s_r.awready;
  assign s_axi_bvalid                   = s_r.bvalid;
  assign s_axi_bresp                    = s_r.bresp;
  assign s_axi_arready                  = s_r.arready;
  assign s_axi_rvalid                   = s_r.rvalid;
  assign s_axi_rresp                    = s_r.rresp;
  assign s_axi_rdata                    = s_r.rdata;
  assign hs_gate                        = s_r.hs;
  assign ls_gate                        = s_r.ls;
  assign ref_on                         = s_r.ref_on;
  assign osc_on                         = s_r.osc_on;
  assign ilim_step                      = s_r.ilim;
  assign output_in_regulation_flag_o    = 1'b0; // Open drain pulls low
  assign output_in_regulation_flag_oe_n = s_r.pg_oe_n;
  assign low_supply_warning_out_o       = 1'b0; // Open drain pulls low
  assign low_supply_warning_out_oe_n    = s_r.lbo_oe_n;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  property p_no_shoot;
    !(hs_gate && ls_gate);
  endproperty
  a_no_shoot: assert property (p_no_shoot)
    else $error("both switches on");

  property p_input_undervoltage_lockout_off;
    input_undervoltage_lockout_s |=> !hs_gate && !ls_gate;
  endproperty
  a_input_undervoltage_lockout_off: assert property (p_input_undervoltage_lockout_off)
    else $error("switch on under undervoltage");

  property p_en_low;
    !en_s |=> !hs_gate && !ls_gate && !output_in_regulation_flag_oe_n
              && low_supply_warning_out_oe_n;
  endproperty
  a_en_low: assert property (p_en_low)
    else $error("not shut down with enable low");

  property p_ot_off;
    en_s && ot_s |=> output_in_regulation_flag_oe_n && !hs_gate && ref_on;
  endproperty
  a_ot_off: assert property (p_ot_off)
    else $error("thermal shutdown not honoured");

  property p_lock;
    sync_rise |=> s_r.sync_lock ##1 !s_r.pfm;
  endproperty
  a_lock: assert property (p_lock)
    else $error("no lock on sync edge");

  property p_loss;
    s_r.sync_lock && !sync_rise && s_r.sync_cnt == 6'(SYNC_LOSS - 1)
      |=> !s_r.sync_lock;
  endproperty
  a_loss: assert property (p_loss)
    else $error("lock not dropped");

  property p_pfm_entry;
    $rose(s_r.pfm) |-> $past(s_r.low_cnt) == 6'(PFM_ENTRY);
  endproperty
  a_pfm_entry: assert property (p_pfm_entry)
    else $error("power save entered early");

  property p_prebias;
    ls_gate |-> s_r.prebias_ok;
  endproperty
  a_prebias: assert property (p_prebias)
    else $error("rectifier on before ramp");

  property p_pg_delay;
    $rose(s_r.pg_valid) |-> $past(s_r.pg_cnt) == 12'(PG_DELAY - 1);
  endproperty
  a_pg_delay: assert property (p_pg_delay)
    else $error("flag valid too early");

endmodule // bcm_ctrl

/* design/bcm_defines.svh */
`ifndef BCM_DEFINES_SVH
`define BCM_DEFINES_SVH

// ****************************************************************
// Register map
// ****************************************************************
`define BCM_ADDR_CTRL     8'h00
`define BCM_ADDR_STATUS   8'h04
`define BCM_CTRL_FPWM     0
`define BCM_CTRL_RESET    32'h00000000
`define BCM_RESP_OKAY     2'h0
`define BCM_RESP_SLVERR   2'h2

// Status field positions
`define BCM_ST_RUN        0
`define BCM_ST_PFM        1
`define BCM_ST_LOCK       2
`define BCM_ST_SSDONE     3
`define BCM_ST_ILIM_LO    4
`define BCM_ST_ILIM_HI    5
`define BCM_ST_PGVALID    6
`define BCM_ST_HS         7
`define BCM_ST_LS         8
`define BCM_ST_PGPIN      9
`define BCM_ST_LBOPIN     10
`define BCM_ST_PREBIAS    11

// ****************************************************************
// Synchronised input positions
// ****************************************************************
`define BCM_IX_EN         0
`define BCM_IX_SYNC       1
`define BCM_IX_INPUT_UNDERVOLTAGE_LOCKOUT       2
`define BCM_IX_OT         3
`define BCM_IX_TRIP       4
`define BCM_IX_CLIM       5
`define BCM_IX_LOWAVG     6
`define BCM_IX_BELOW      7
`define BCM_IX_ABOVE      8
`define BCM_IX_LOW16      9
`define BCM_IX_ZERO       10
`define BCM_IX_PREBIAS    11
`define BCM_IX_DROP       12
`define BCM_IX_GOOD       13
`define BCM_IX_LBTRIP     14
`define BCM_IX_PGPIN      15
`define BCM_IX_LBOPIN     16
`define BCM_IN_W          17

// ****************************************************************
// Timing
// ****************************************************************
`define BCM_CLK_HZ        10000000
`define BCM_OSC_HZ        1000000
`define BCM_OSC_DIV       (`BCM_CLK_HZ / `BCM_OSC_HZ)
`define BCM_SS_STEP_US    250
`define BCM_SS_STEP_CYC   ((`BCM_SS_STEP_US * (`BCM_CLK_HZ / 1000000)))
`define BCM_PG_DELAY_US   250
`define BCM_PG_DELAY_CYC  ((`BCM_PG_DELAY_US * (`BCM_CLK_HZ / 1000000)))
`define BCM_SYNC_LOSS_PER 4
`define BCM_SYNC_LOSS_CYC (`BCM_SYNC_LOSS_PER * `BCM_OSC_DIV)
`define BCM_PFM_ENTRY_PER 32
`define BCM_MIN_DUTY_PCT  10
`define BCM_MIN_ON_CYC    ((`BCM_OSC_DIV * `BCM_MIN_DUTY_PCT + 99) / 100)
`define BCM_DEAD_NS       100
`define BCM_DEAD_CYC      ((`BCM_DEAD_NS * (`BCM_CLK_HZ / 1000000) + 999) / 1000)

`endif

/* design/bcm_pkg.sv */
package bcm_pkg;

  // Switching phase of the power stage
  typedef enum logic [2:0]
  {
    PH_IDLE,
    PH_DEAD_H,
    PH_HS,
    PH_DEAD_L,
    PH_LS
  } bcm_phase_t;

  // Whole state of the control block
  typedef struct packed {
    bcm_phase_t  phase;
    logic [3:0]  ph_cnt;
    logic [3:0]  osc_cnt;
    logic [5:0]  sync_cnt;
    logic        sync_lock;
    logic        sync_prev;
    logic        en_prev;
    logic        run;
    logic [1:0]  ss_step;
    logic        ss_done;
    logic [11:0] ss_cnt;
    logic        prebias_ok;
    logic [11:0] pg_cnt;
    logic        pg_valid;
    logic [5:0]  low_cnt;
    logic        pfm;
    logic        burst;
    logic        pulsed;
    logic        hs;
    logic        ls;
    logic [1:0]  ilim;
    logic        ref_on;
    logic        osc_on;
    logic        pg_oe_n;
    logic        lbo_oe_n;
    logic        force_pwm;
    logic        awready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [1:0]  rresp;
    logic [31:0] rdata;
  } bcm_state_t;

endpackage

/* design/bcm_sync_if.sv */
`timescale 1ns/1ps

// Raw asynchronous inputs in, synchronised copies out
interface bcm_sync_if #(parameter int W = 1) ();
  logic [W-1:0] raw;
  logic [W-1:0] sync;
  modport ctl (output raw, input sync);
  modport syn (input raw, output sync);
endinterface

/* design/bcm_sync.sv */
`timescale 1ns/1ps

// ****************************************************************
// Two-stage input synchroniser
// ****************************************************************
module bcm_sync #(
  parameter int W = 1
) (
  input wire logic aclk,
  input wire logic aresetn,
  bcm_sync_if.syn  s
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] sync;
  } bcm_sync_state_t;

  bcm_sync_state_t s_r;
  bcm_sync_state_t s_nxt;

  // First stage feeds only the second
  always_comb
  begin
    s_nxt      = s_r;
    s_nxt.meta = s.raw;
    s_nxt.sync = s_r.meta;
  end

  // State register
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  assign s.sync = s_r.sync;

endmodule // bcm_sync

/* tb/bcm_sys_model.sv */
`timescale 1ns/1ps

// System side: drives the enable pin and the sync clock or level
module bcm_sys_model (
  input  wire logic en_cmd,
  input  wire logic clk_run,
  input  wire logic lvl,
  output wire logic enable_pin,
  output wire logic sync_pin
);
  logic ck = 1'b0;

  always #400 ck = ~ck;

  // clock only while commanded, else a static level
  assign sync_pin   = clk_run ? ck : lvl;
  assign enable_pin = en_cmd;
endmodule // bcm_sys_model

/* tb/tb.sv */
`timescale 1ns/1ps

module tb;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  wire s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp, ilim_step;
  wire [31:0] s_axi_rdata;
  logic en_cmd = 0, clk_run = 0, lvl = 0;
  wire enable_pin, sync_pin;
  logic input_undervoltage_lockout = 0, over_temp = 0, reg_trip = 0;
  logic hs_cur_limit = 0, low_avg_cur = 0, out_below_nom = 0;
  logic out_above_hi = 0, out_below_low = 0, ind_cur_zero = 0;
  logic ramp_above_prebias = 0, vin_near_vout = 0, out_good_cmp = 1;
  logic low_supply_cmp = 0;
  wire output_in_regulation_flag_i, output_in_regulation_flag_o;
  wire output_in_regulation_flag_oe_n, low_supply_warning_out_i;
  wire low_supply_warning_out_o, low_supply_warning_out_oe_n;
  wire hs_gate, ls_gate, ref_on, osc_on;
  int mismatches = 0;
  int n_tests = 0;
  int n;
  int m;
  logic [31:0] rd;
  logic [1:0] rs;
  logic seen;

  // Clock and pull-ups on the open-drain pins
  always #50 aclk = ~aclk;
  assign output_in_regulation_flag_i = output_in_regulation_flag_oe_n;
  assign low_supply_warning_out_i = low_supply_warning_out_oe_n;

  bcm_sys_model sys (.en_cmd, .clk_run, .lvl, .enable_pin, .sync_pin);

  bcm_ctrl #(.SS_STEP(20), .PG_DELAY(20), .PFM_ENTRY(4)) DUT (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .enable_pin, .sync_pin,
    .input_undervoltage_lockout, .over_temp, .reg_trip, .hs_cur_limit,
    .low_avg_cur, .out_below_nom, .out_above_hi, .out_below_low,
    .ind_cur_zero, .ramp_above_prebias, .vin_near_vout, .out_good_cmp,
    .low_supply_cmp, .output_in_regulation_flag_i,
    .output_in_regulation_flag_o, .output_in_regulation_flag_oe_n,
    .low_supply_warning_out_i, .low_supply_warning_out_o,
    .low_supply_warning_out_oe_n, .hs_gate, .ls_gate, .ref_on, .osc_on,
    .ilim_step
  );

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  // AXI write, response code left in rs
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do @(posedge aclk); while (s_axi_awready !== 1'b1);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    s_axi_bready <= 1'b1;
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  // AXI read, data in rd and response in rs
  task automatic rdr(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  // Counts cycles until the high-side gate reaches v
  task automatic wait_hs(input logic v);
    do
    begin
      @(posedge aclk);
      n++;
      seen |= ls_gate;
    end
    while (hs_gate !== v);
  endtask

  // Settles, then counts gate-on cycles over 20 clocks: hs in n, ls in m
  task automatic gates(input int settle);
    repeat (settle) @(posedge aclk);
    n = 0;
    m = 0;
    repeat (20)
    begin
      @(posedge aclk);
      n += hs_gate;
      m += ls_gate;
    end
  endtask

  task automatic t_off;
    repeat (5) @(posedge aclk);
    chk({hs_gate, ls_gate, ref_on, osc_on}, 4'h0);
    chk({output_in_regulation_flag_oe_n, low_supply_warning_out_oe_n}, 2'h1);
    chk({output_in_regulation_flag_o, low_supply_warning_out_o}, 2'h0);
  endtask

  task automatic t_regs;
    rdr(8'h00);
    chk(rd, 32'h0);
    wr(8'h00, 32'h1);
    chk({30'h0, rs}, 32'h0);
    rdr(8'h00);
    chk(rd, 32'h1);
    wr(8'h00, 32'h0);
    rdr(8'h0C);
    chk({30'h0, rs}, 32'h2);
  endtask

  task automatic t_start;
    en_cmd <= 1'b1;
    do @(posedge aclk); while (ilim_step !== 2'h1);
    n = 0;
    do
    begin
      @(posedge aclk);
      n++;
    end
    while (ilim_step !== 2'h2);
    chk(n, 20);
    do @(posedge aclk); while (ilim_step !== 2'h3);
    chk(output_in_regulation_flag_oe_n, 1'b1);
  endtask

  task automatic t_pwm;
    reg_trip <= 1'b1;
    wait_hs(1'b0);
    wait_hs(1'b1);
    seen = 1'b0;
    wait_hs(1'b0);
    wait_hs(1'b1);
    chk(seen, 1'b0);
    ramp_above_prebias <= 1'b1;
    wait_hs(1'b0);
    wait_hs(1'b1);
    n = 0;
    seen = 1'b0;
    wait_hs(1'b0);
    wait_hs(1'b1);
    chk(n, 10);
    chk(seen, 1'b1);
  endtask

  // Dropout, current limit, light-load rectifier and forced PWM pin
  task automatic t_modes;
    vin_near_vout <= 1'b1;
    gates(15);
    chk(n, 20);
    hs_cur_limit <= 1'b1;
    gates(15);
    chk(n, 2);
    hs_cur_limit <= 1'b0;
    vin_near_vout <= 1'b0;
    ind_cur_zero <= 1'b1;
    gates(15);
    chk(m, 2);
    lvl <= 1'b1;
    gates(60);
    chk(m, 14);
    lvl <= 1'b0;
    ind_cur_zero <= 1'b0;
  endtask

  task automatic t_input_undervoltage_lockout;
    input_undervoltage_lockout <= 1'b1;
    repeat (4) @(posedge aclk);
    seen = 1'b0;
    repeat (30)
    begin
      @(posedge aclk);
      seen |= hs_gate | ls_gate;
    end
    chk(seen, 1'b0);
    input_undervoltage_lockout <= 1'b0;
  endtask

  task automatic t_sync;
    low_avg_cur <= 1'b1;
    clk_run <= 1'b1;
    repeat (60) @(posedge aclk);
    rdr(8'h04);
    chk(rd[2:1], 2'h2);
    wait_hs(1'b0);
    wait_hs(1'b1);
    n = 0;
    wait_hs(1'b0);
    wait_hs(1'b1);
    chk(n, 8);
    clk_run <= 1'b0;
    repeat (60) @(posedge aclk);
    rdr(8'h04);
    chk(rd[2], 1'b0);
    repeat (60) @(posedge aclk);
    rdr(8'h04);
    chk(rd[1], 1'b1);
    out_below_low <= 1'b1;
    repeat (5) @(posedge aclk);
    rdr(8'h04);
    chk(rd[1], 1'b0);
  endtask

  task automatic t_ot;
    over_temp <= 1'b1;
    low_supply_cmp <= 1'b1;
    repeat (5) @(posedge aclk);
    chk({ref_on, hs_gate, ls_gate}, 3'h4);
    chk(output_in_regulation_flag_oe_n, 1'b1);
    chk(low_supply_warning_out_oe_n, 1'b0);
    en_cmd <= 1'b0;
    repeat (5) @(posedge aclk);
    chk({ref_on, hs_gate, ls_gate}, 3'h4);
    chk(low_supply_warning_out_oe_n, 1'b1);
  endtask

  task automatic conclude;
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Watchdog
  initial
  begin
    #2000000;
    mismatches++;
    conclude();
  end

  // Main sequence
  initial
  begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    t_off();
    t_regs();
    t_start();
    t_pwm();
    t_modes();
    t_input_undervoltage_lockout();
    t_sync();
    t_ot();
    conclude();
  end
endmodule // tb
